// file: header_field_and_probe_map.vh
// Register offsets, field positions, reset values and probe selector codes
`ifndef HEADER_FIELD_AND_PROBE_MAP_VH
`define HEADER_FIELD_AND_PROBE_MAP_VH

// Register byte offsets on the control port
`define OFS_RATE_CODE_0      8'h40
`define OFS_RATE_CODE_1      8'h44
`define OFS_RATE_CODE_2      8'h48
`define OFS_RATE_CODE_3      8'h4C
`define OFS_TX_SERVICE       8'h54
`define OFS_TX_LENGTH_HIGH   8'h58
`define OFS_TX_LENGTH_LOW    8'h5C
`define OFS_RECEIVE_STATUS   8'h60
`define OFS_RX_SERVICE       8'h64
`define OFS_RX_LENGTH_HIGH   8'h68
`define OFS_RX_LENGTH_LOW    8'h6C
`define OFS_PROBE_SELECT     8'h70
`define OFS_PROBE_MONITOR    8'h74

// Reset values
`define RST_RATE_CODE_0      8'h0A
`define RST_RATE_CODE_1      8'h14
`define RST_RATE_CODE_2      8'h37
`define RST_RATE_CODE_3      8'h6E
`define RST_TX_SERVICE       8'h00
`define RST_TX_LENGTH        8'h00
`define RST_PROBE_SELECT     8'h00
`define RST_BYTE             8'h00

// Receive status bit positions
`define ST_RATE_HI           7
`define ST_RATE_LO           6
`define ST_CARRIER           5
`define ST_SFD               4
`define ST_SIG_VALID         3
`define ST_CRC_VALID         2
`define ST_ANTENNA           1
`define ST_ZERO              0

// Probe selector codes
`define PSEL_QUIET           8'h00
`define PSEL_RX_MONITOR      8'h01
`define PSEL_TX_MONITOR      8'h02
`define PSEL_RSSI            8'h03
`define PSEL_SQ_FIRST        8'h04
`define PSEL_SQ_SECOND       8'h05
`define PSEL_CORRELATOR      8'h06

// Nominal spacing of receive progress flags after SFD detect, in microseconds
`define RX_SIG_READY_US      8
`define RX_LEN_READY_US      32
`define RX_CRC_READY_US      48

`endif

// file: probe_mux.v
// Probe source selector: routes one internal signal group onto the probe byte and strobe
`timescale 1ns/1ps
`include "header_field_and_probe_map.vh"

module probe_mux (
    // Selector
    input  wire [7:0] select_i,
    // Receive progress
    input  wire       adc_cal_full_i,
    input  wire       carrier_sense_flag_i,
    input  wire       energy_detect_flag_i,
    input  wire       track_start_i,
    input  wire       sfd_detect_i,
    input  wire       signal_field_ready_i,
    input  wire       length_ready_i,
    input  wire       header_crc_ok_i,
    input  wire       initial_detect_i,
    // Transmit progress
    input  wire       transmit_path_enable_i,
    input  wire       preamble_start_i,
    input  wire       signal_field_start_i,
    input  wire       length_field_start_i,
    input  wire       crc_field_start_i,
    input  wire       payload_start_i,
    input  wire       symbol_boundary_mark_i,
    // Signal strength and quality
    input  wire       early_carrier_sense_enh_i,
    input  wire       early_carrier_sense_i,
    input  wire [5:0] rssi_i,
    input  wire       rssi_clk_i,
    input  wire [7:0] signal_quality_one_i,
    input  wire [7:0] signal_quality_two_i,
    input  wire [7:0] signal_quality_three_i,
    input  wire       sq_three_diversity_i,
    input  wire       sq_valid_i,
    // Correlator
    input  wire [7:0] corr_magnitude_i,
    input  wire       sample_clk_i,
    // Selected value
    output reg  [7:0] probe_o,
    output reg        strobe_o
);

    always @* begin
        probe_o  = 8'h00;
        strobe_o = 1'b0;
        case (select_i)
            `PSEL_QUIET: begin
                probe_o  = 8'h00;
                strobe_o = 1'b0;
            end
            `PSEL_RX_MONITOR: begin
                // Progress flags already rise on chip edges and drop after the last chip
                probe_o  = {adc_cal_full_i, carrier_sense_flag_i, energy_detect_flag_i, track_start_i,
                            sfd_detect_i, signal_field_ready_i, length_ready_i, header_crc_ok_i};
                strobe_o = initial_detect_i;
            end
            `PSEL_TX_MONITOR: begin
                probe_o  = {adc_cal_full_i, transmit_path_enable_i, preamble_start_i, 1'b0,
                            signal_field_start_i, length_field_start_i, crc_field_start_i,
                            payload_start_i};
                strobe_o = symbol_boundary_mark_i;
            end
            `PSEL_RSSI: begin
                probe_o  = {early_carrier_sense_enh_i, early_carrier_sense_i, rssi_i};
                strobe_o = rssi_clk_i;
            end
            `PSEL_SQ_FIRST: begin
                probe_o  = signal_quality_one_i;
                strobe_o = sq_valid_i;
            end
            `PSEL_SQ_SECOND: begin
                probe_o  = sq_three_diversity_i ? signal_quality_three_i : signal_quality_two_i;
                strobe_o = sq_valid_i;
            end
            `PSEL_CORRELATOR: begin
                probe_o  = corr_magnitude_i;
                strobe_o = sample_clk_i;
            end
            default: begin
                probe_o  = 8'h00;
                strobe_o = 1'b0;
            end
        endcase
    end

endmodule

// file: header_field_and_probe_regs.v
// Header field, receive status and probe selector registers of the baseband processor
`timescale 1ns/1ps
`include "header_field_and_probe_map.vh"

// How it works
// - Transmit service register value is sent as every outgoing header's Service field.
// - Transmit Length is high register bits 15:8 and low register bits 7:0.
// - Status bits 7:6 give detected rate code; the register is read only.
// - Status bit 5 shows carrier acquired, forced low while receive is disabled.
// - Status bit 4 shows SFD found, cleared while receive is disabled.
// - Status bit 3 set only if signal field matches a rate code register.
// - Status bit 2 shows header CRC valid, cleared while receive is disabled.
// - Status bit 1 holds antenna at last valid CRC; bit 0 reads zero.
// - Receive service register holds the Service byte of the latest header.
// - Receive length registers hold the captured Length, high and low bytes.
// - Probe select register picks probe outputs, strobe and monitor read value.
// - Selector zero holds all probe outputs and strobe low.
// - Selector 01h shows receive progress flags on the probe bits.
// - Receive flags follow SFD at about 8, 32, 48 us; strobe marks detection.
// - Selector 02h shows transmit progress flags; strobe marks symbol boundaries.
// - Selector 03h shows early carrier senses and RSSI; strobe is RSSI clock.
// - Selectors 04h, 05h show first or second/third signal quality byte.
// - Selector 06h shows correlator magnitude; strobe is the sample clock.
// - Four rate code registers feed transmit signal field and receive classification.
// - Probe monitor register reads back the currently selected probe byte.
module header_field_and_probe_regs (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    // Control port register access
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    output reg         reg_rvalid_o,
    // Transmit header fields
    input  wire [1:0]  tx_rate_sel_i,
    output reg  [7:0]  tx_signal_code_o,
    output reg  [7:0]  tx_service_o,
    output reg  [15:0] tx_length_o,
    // Receive header events from the demodulator
    input  wire        receive_path_enable_i,
    input  wire        carrier_acquired_i,
    input  wire        sfd_found_i,
    input  wire [7:0]  rx_signal_i,
    input  wire        rx_signal_valid_i,
    input  wire [7:0]  rx_service_i,
    input  wire        rx_service_valid_i,
    input  wire [15:0] rx_length_i,
    input  wire        rx_length_valid_i,
    input  wire        header_crc_ok_i,
    input  wire        antenna_a_i,
    // Receive progress flags
    input  wire        adc_cal_full_i,
    input  wire        carrier_sense_flag_i,
    input  wire        energy_detect_flag_i,
    input  wire        track_start_i,
    input  wire        sfd_detect_i,
    input  wire        signal_field_ready_i,
    input  wire        length_ready_i,
    input  wire        crc_ready_i,
    input  wire        initial_detect_i,
    // Transmit progress flags
    input  wire        transmit_path_enable_i,
    input  wire        preamble_start_i,
    input  wire        signal_field_start_i,
    input  wire        length_field_start_i,
    input  wire        crc_field_start_i,
    input  wire        payload_start_i,
    input  wire        symbol_boundary_mark_i,
    // Signal strength, quality and correlator
    input  wire        early_carrier_sense_enh_i,
    input  wire        early_carrier_sense_i,
    input  wire [5:0]  rssi_i,
    input  wire        rssi_clk_i,
    input  wire [7:0]  signal_quality_one_i,
    input  wire [7:0]  signal_quality_two_i,
    input  wire [7:0]  signal_quality_three_i,
    input  wire        sq_three_diversity_i,
    input  wire        sq_valid_i,
    input  wire [7:0]  corr_magnitude_i,
    input  wire        sample_clk_i,
    // Probe outputs
    output reg  [7:0]  probe_o,
    output reg         probe_strobe_o
);

    // Rate code registers, one byte each
    reg  [7:0] rate_code_q [0:3];
    reg  [7:0] tx_service_value_q;
    reg  [7:0] tx_length_high_q;
    reg  [7:0] tx_length_low_q;
    reg  [7:0] probe_select_q;

    // Receive status fields
    reg  [1:0] rate_q;
    reg        carrier_q;
    reg        sfd_q;
    reg        sig_valid_q;
    reg        crc_valid_q;
    reg        antenna_q;
    reg  [7:0] rx_service_capture_q;
    reg  [7:0] rx_length_high_q;
    reg  [7:0] rx_length_low_q;

    wire [7:0] probe_sel;
    wire       strobe_sel;
    wire [7:0] receive_status;
    wire [3:0] code_hit;
    reg  [1:0] hit_index;
    reg  [7:0] rdata_d;

    // Control port writes; read-only offsets are ignored
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rate_code_q[0]     <= `RST_RATE_CODE_0;
            rate_code_q[1]     <= `RST_RATE_CODE_1;
            rate_code_q[2]     <= `RST_RATE_CODE_2;
            rate_code_q[3]     <= `RST_RATE_CODE_3;
            tx_service_value_q <= `RST_TX_SERVICE;
            tx_length_high_q   <= `RST_TX_LENGTH;
            tx_length_low_q    <= `RST_TX_LENGTH;
            probe_select_q     <= `RST_PROBE_SELECT;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `OFS_RATE_CODE_0:    rate_code_q[0]     <= reg_wdata_i;
                `OFS_RATE_CODE_1:    rate_code_q[1]     <= reg_wdata_i;
                `OFS_RATE_CODE_2:    rate_code_q[2]     <= reg_wdata_i;
                `OFS_RATE_CODE_3:    rate_code_q[3]     <= reg_wdata_i;
                // Service is reserved; software is expected to keep it at zero
                `OFS_TX_SERVICE:     tx_service_value_q <= reg_wdata_i;
                `OFS_TX_LENGTH_HIGH: tx_length_high_q   <= reg_wdata_i;
                `OFS_TX_LENGTH_LOW:  tx_length_low_q    <= reg_wdata_i;
                `OFS_PROBE_SELECT:   probe_select_q     <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // Transmit header fields, registered so they stay stable across a write
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            tx_service_o     <= `RST_BYTE;
            tx_length_o      <= {`RST_BYTE, `RST_BYTE};
            tx_signal_code_o <= `RST_BYTE;
        end else begin
            tx_service_o     <= tx_service_value_q;
            tx_length_o      <= {tx_length_high_q, tx_length_low_q};
            tx_signal_code_o <= rate_code_q[tx_rate_sel_i];
        end
    end

    // Compare the received signal field against all four rate codes at once
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : match
            assign code_hit[g] = (rx_signal_i == rate_code_q[g]);
        end
    endgenerate

    // Lowest matching index wins if software programmed duplicate codes
    always @* begin
        hit_index = 2'd0;
        if (code_hit[0]) begin
            hit_index = 2'd0;
        end else if (code_hit[1]) begin
            hit_index = 2'd1;
        end else if (code_hit[2]) begin
            hit_index = 2'd2;
        end else if (code_hit[3]) begin
            hit_index = 2'd3;
        end
    end

    // Receive status; disabling the receive path clears the progress bits
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rate_q      <= 2'd0;
            carrier_q   <= 1'b0;
            sfd_q       <= 1'b0;
            sig_valid_q <= 1'b0;
            crc_valid_q <= 1'b0;
            antenna_q   <= 1'b0;
        end else if (!receive_path_enable_i) begin
            carrier_q   <= 1'b0;
            sfd_q       <= 1'b0;
            sig_valid_q <= 1'b0;
            crc_valid_q <= 1'b0;
        end else begin
            carrier_q <= carrier_acquired_i;
            if (sfd_found_i) begin
                sfd_q <= 1'b1;
            end
            if (rx_signal_valid_i) begin
                sig_valid_q <= |code_hit;
                if (|code_hit) begin
                    rate_q <= hit_index;
                end
            end
            if (header_crc_ok_i) begin
                crc_valid_q <= 1'b1;
                antenna_q   <= antenna_a_i;
            end
        end
    end

    // Captured header fields hold until the next header delivers new ones
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rx_service_capture_q <= `RST_BYTE;
            rx_length_high_q     <= `RST_BYTE;
            rx_length_low_q      <= `RST_BYTE;
        end else begin
            if (rx_service_valid_i) begin
                rx_service_capture_q <= rx_service_i;
            end
            if (rx_length_valid_i) begin
                rx_length_high_q <= rx_length_i[15:8];
                rx_length_low_q  <= rx_length_i[7:0];
            end
        end
    end

    assign receive_status = {rate_q, carrier_q, sfd_q, sig_valid_q, crc_valid_q, antenna_q, 1'b0};

    probe_mux u_probe_mux (
        .select_i                  (probe_select_q),
        .adc_cal_full_i            (adc_cal_full_i),
        .carrier_sense_flag_i      (carrier_sense_flag_i),
        .energy_detect_flag_i      (energy_detect_flag_i),
        .track_start_i             (track_start_i),
        .sfd_detect_i              (sfd_detect_i),
        .signal_field_ready_i      (signal_field_ready_i),
        .length_ready_i            (length_ready_i),
        .header_crc_ok_i           (crc_ready_i),
        .initial_detect_i          (initial_detect_i),
        .transmit_path_enable_i    (transmit_path_enable_i),
        .preamble_start_i          (preamble_start_i),
        .signal_field_start_i      (signal_field_start_i),
        .length_field_start_i      (length_field_start_i),
        .crc_field_start_i         (crc_field_start_i),
        .payload_start_i           (payload_start_i),
        .symbol_boundary_mark_i    (symbol_boundary_mark_i),
        .early_carrier_sense_enh_i (early_carrier_sense_enh_i),
        .early_carrier_sense_i     (early_carrier_sense_i),
        .rssi_i                    (rssi_i),
        .rssi_clk_i                (rssi_clk_i),
        .signal_quality_one_i      (signal_quality_one_i),
        .signal_quality_two_i      (signal_quality_two_i),
        .signal_quality_three_i    (signal_quality_three_i),
        .sq_three_diversity_i      (sq_three_diversity_i),
        .sq_valid_i                (sq_valid_i),
        .corr_magnitude_i          (corr_magnitude_i),
        .sample_clk_i              (sample_clk_i),
        .probe_o                   (probe_sel),
        .strobe_o                  (strobe_sel)
    );

    // Probe pins are registered: one cycle of lag, but no glitches while the selector changes
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            probe_o        <= `RST_BYTE;
            probe_strobe_o <= 1'b0;
        end else begin
            probe_o        <= probe_sel;
            probe_strobe_o <= strobe_sel;
        end
    end

    // Read mux; unmapped offsets read as zero
    always @* begin
        rdata_d = `RST_BYTE;
        case (reg_addr_i)
            `OFS_RATE_CODE_0:    rdata_d = rate_code_q[0];
            `OFS_RATE_CODE_1:    rdata_d = rate_code_q[1];
            `OFS_RATE_CODE_2:    rdata_d = rate_code_q[2];
            `OFS_RATE_CODE_3:    rdata_d = rate_code_q[3];
            `OFS_TX_SERVICE:     rdata_d = tx_service_value_q;
            `OFS_TX_LENGTH_HIGH: rdata_d = tx_length_high_q;
            `OFS_TX_LENGTH_LOW:  rdata_d = tx_length_low_q;
            `OFS_RECEIVE_STATUS: rdata_d = receive_status;
            `OFS_RX_SERVICE:     rdata_d = rx_service_capture_q;
            `OFS_RX_LENGTH_HIGH: rdata_d = rx_length_high_q;
            `OFS_RX_LENGTH_LOW:  rdata_d = rx_length_low_q;
            `OFS_PROBE_SELECT:   rdata_d = probe_select_q;
            `OFS_PROBE_MONITOR:  rdata_d = probe_o;
            default:             rdata_d = `RST_BYTE;
        endcase
    end

    // Reads only sample state, so they never disturb the receiver
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            reg_rdata_o  <= `RST_BYTE;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
        end
    end

endmodule

// file: hfpr_sva.sv
// Assertion checker for the header field and probe register block
`timescale 1ns/1ps
module hfpr_sva (
    // Clock and reset
    input wire        clk_i,
    input wire        rstn_i,
    // Register port
    input wire [7:0]  reg_addr_i,
    input wire [7:0]  reg_wdata_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [7:0]  reg_rdata_o,
    // Header fields and probe
    input wire [7:0]  tx_service_o,
    input wire [15:0] tx_length_o,
    input wire        receive_path_enable_i,
    input wire [7:0]  rx_service_i,
    input wire        rx_service_valid_i,
    input wire [7:0]  probe_o,
    input wire        probe_strobe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    wire sel_wr = reg_wr_i && reg_addr_i == 8'h70;
    wire st_rd  = reg_rd_i && reg_addr_i == 8'h60;

    tx_service_a: assert property (reg_wr_i && reg_addr_i == 8'h54 |-> ##2 tx_service_o == $past(reg_wdata_i, 2))
        else $error("service output wrong");
    len_high_a: assert property (reg_wr_i && reg_addr_i == 8'h58 |-> ##2 tx_length_o[15:8] == $past(reg_wdata_i, 2))
        else $error("length high wrong");
    len_low_a: assert property (reg_wr_i && reg_addr_i == 8'h5C |-> ##2 tx_length_o[7:0] == $past(reg_wdata_i, 2))
        else $error("length low wrong");
    quiet_probe_a: assert property (sel_wr && reg_wdata_i == 8'h00 ##1 !sel_wr |=> probe_o == 8'h00 && !probe_strobe_o)
        else $error("probe not quiet");
    monitor_read_a: assert property (reg_rd_i && reg_addr_i == 8'h74 |=> reg_rdata_o == $past(probe_o))
        else $error("monitor read wrong");
    status_clear_a: assert property (!receive_path_enable_i [*2] ##0 st_rd |=> reg_rdata_o[5:2] == 4'h0)
        else $error("status not cleared");
    status_zero_a: assert property (st_rd |=> !reg_rdata_o[0])
        else $error("status bit zero set");
    rx_capture_a: assert property (rx_service_valid_i ##1 (reg_rd_i && reg_addr_i == 8'h64) |=> reg_rdata_o == $past(rx_service_i, 2))
        else $error("service capture wrong");

    cover property (sel_wr && reg_wdata_i == 8'h03);
    cover property (st_rd && receive_path_enable_i);
    cover property (rx_service_valid_i ##1 reg_rd_i);
endmodule

bind header_field_and_probe_regs hfpr_sva i_hfpr_sva (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_service_o(tx_service_o),
    .tx_length_o(tx_length_o), .receive_path_enable_i(receive_path_enable_i), .rx_service_i(rx_service_i),
    .rx_service_valid_i(rx_service_valid_i), .probe_o(probe_o), .probe_strobe_o(probe_strobe_o)
);

// file: mac_host.sv
// Host controller model that issues register writes and reads
`timescale 1ns/1ps
module mac_host (
    // Clock
    input  wire       clk_i,
    // Register port
    output reg  [7:0] addr_o,
    output reg  [7:0] wdata_o,
    output reg        wr_o,
    output reg        rd_o,
    input  wire [7:0] rdata_i,
    input  wire       rvalid_i
);
    integer w;
    initial {addr_o, wdata_o, wr_o, rd_o} = 18'h0_0000;
    // Called after a falling edge; the idle cycle at the end keeps strobes from merging
    task write_reg(input [7:0] a, input [7:0] d);
        begin
            addr_o = a;
            wdata_o = d;
            wr_o = 1'b1;
            @(negedge clk_i);
            wr_o = 1'b0;
            addr_o = ~a;
            wdata_o = ~d;
            @(negedge clk_i);
        end
    endtask
    task read_reg(input [7:0] a, output [7:0] d, output ok);
        begin
            addr_o = a;
            rd_o = 1'b1;
            @(negedge clk_i);
            rd_o = 1'b0;
            addr_o = ~a;
            w = 0;
            while (rvalid_i !== 1'b1 && w < 4) begin
                @(negedge clk_i);
                w = w + 1;
            end
            ok = rvalid_i === 1'b1;
            d = rdata_i;
            @(negedge clk_i);
        end
    endtask
    // Service field is reserved, so the host parks it at zero
    task park_service;
        begin
            write_reg(8'h54, 8'h00);
        end
    endtask
endmodule

// file: header_field_and_probe_regs_tb.sv
// Self-checking bench for the header field and probe register block
`timescale 1ns/1ps
module header_field_and_probe_regs_tb;
    reg         clk = 1'b0, rstn = 1'b0, en = 1'b0, car = 1'b0, sfd = 1'b0, crc = 1'b0, ant = 1'b0, div = 1'b0;
    reg         rsig_v = 1'b0, rsvc_v = 1'b0, rlen_v = 1'b0, ok, es;
    reg  [1:0]  rsel = 2'b00;
    reg  [4:0]  st = 5'h00;
    reg  [7:0]  rsig = 8'h00, rsvc = 8'h00, pa = 8'h00, pb = 8'h00, pc = 8'h00, pd = 8'h00, got, ep;
    reg  [15:0] rlen = 16'h0000;
    reg  [7:0]  rc [0:3];
    wire [7:0]  addr, wdata, rdata, sig_code, svc, probe;
    wire [15:0] tlen;
    wire        wr, rd, rvalid, pstb;
    integer     n_errors = 0, total_checks = 0, cycles = 0, k, m;

    always #2 clk = ~clk;

    mac_host i_mac_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata),
        .rvalid_i(rvalid));

    header_field_and_probe_regs i_header_field_and_probe_regs (
        .clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .tx_rate_sel_i(rsel), .tx_signal_code_o(sig_code),
        .tx_service_o(svc), .tx_length_o(tlen), .receive_path_enable_i(en), .carrier_acquired_i(car),
        .sfd_found_i(sfd), .rx_signal_i(rsig), .rx_signal_valid_i(rsig_v), .rx_service_i(rsvc),
        .rx_service_valid_i(rsvc_v), .rx_length_i(rlen), .rx_length_valid_i(rlen_v), .header_crc_ok_i(crc),
        .antenna_a_i(ant), .adc_cal_full_i(pa[7]), .carrier_sense_flag_i(pa[6]), .energy_detect_flag_i(pa[5]),
        .track_start_i(pa[4]), .sfd_detect_i(pa[3]), .signal_field_ready_i(pa[2]), .length_ready_i(pa[1]),
        .crc_ready_i(pa[0]), .initial_detect_i(st[0]), .transmit_path_enable_i(pb[6]),
        .preamble_start_i(pb[5]), .signal_field_start_i(pb[3]), .length_field_start_i(pb[2]),
        .crc_field_start_i(pb[1]), .payload_start_i(pb[0]), .symbol_boundary_mark_i(st[1]),
        .early_carrier_sense_enh_i(pc[7]), .early_carrier_sense_i(pc[6]), .rssi_i(pc[5:0]), .rssi_clk_i(st[2]),
        .signal_quality_one_i(pd), .signal_quality_two_i(~pd), .signal_quality_three_i({pd[3:0], pd[7:4]}),
        .sq_three_diversity_i(div), .sq_valid_i(st[3]), .corr_magnitude_i(pa ^ pd), .sample_clk_i(st[4]),
        .probe_o(probe), .probe_strobe_o(pstb));

    task chk(input [8*16-1:0] name, input [15:0] exp, input [15:0] act);
        begin
            total_checks = total_checks + 1;
            if (act !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED %0s expected %h seen %h", name, exp, act);
            end
        end
    endtask

    task rd_chk(input [8*16-1:0] name, input [7:0] a, input [7:0] exp);
        begin
            i_mac_host.read_reg(a, got, ok);
            chk("rvalid", 16'h0001, {15'h0000, ok});
            chk(name, {8'h00, exp}, {8'h00, got});
        end
    endtask

    task complete_run;
        begin
            if (n_errors == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    task t_reset;
        begin
            chk("quiet", 16'h0000, {7'h00, pstb, probe});
            for (k = 0; k < 4; k = k + 1) begin
                rd_chk("rate_code", 8'h40 + {k[5:0], 2'b00}, rc[k]);
                rsel = k[1:0];
                @(negedge clk);
                @(negedge clk);
                chk("tx_signal", {8'h00, rc[k]}, {8'h00, sig_code});
            end
            for (k = 0; k < 8; k = k + 1)
                rd_chk("reset_value", 8'h54 + {k[5:0], 2'b00}, 8'h00);
            rd_chk("unmapped", 8'h7C, 8'h00);
        end
    endtask

    task t_tx;
        begin
            i_mac_host.write_reg(8'h54, 8'hA5);
            chk("tx_service", 16'h00A5, {8'h00, svc});
            i_mac_host.write_reg(8'h58, 8'h12);
            i_mac_host.write_reg(8'h5C, 8'h34);
            chk("tx_length", 16'h1234, tlen);
            rd_chk("len_high", 8'h58, 8'h12);
            i_mac_host.park_service;
            chk("tx_service", 16'h0000, {8'h00, svc});
        end
    endtask

    task pulse_sig(input [7:0] v);
        begin
            rsig = v;
            rsig_v = 1'b1;
            @(negedge clk);
            rsig_v = 1'b0;
            rsig = ~v;
        end
    endtask

    task t_status;
        begin
            i_mac_host.write_reg(8'h48, 8'h15);
            rc[2] = 8'h15;
            en = 1'b1;
            car = 1'b1;
            sfd = 1'b1;
            @(negedge clk);
            sfd = 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
                pulse_sig(rc[k]);
                rd_chk("status_rate", 8'h60, {k[1:0], 6'b111000});
            end
            pulse_sig(8'h37);
            rd_chk("status_nomatch", 8'h60, 8'hF0);
            ant = 1'b1;
            crc = 1'b1;
            @(negedge clk);
            crc = 1'b0;
            ant = 1'b0;
            rd_chk("status_crc", 8'h60, 8'hF6);
            rd_chk("status_again", 8'h60, 8'hF6);
            crc = 1'b1;
            @(negedge clk);
            crc = 1'b0;
            rd_chk("status_ant_b", 8'h60, 8'hF4);
            i_mac_host.write_reg(8'h60, 8'h00);
            rd_chk("status_ro", 8'h60, 8'hF4);
            en = 1'b0;
            sfd = 1'b1;
            repeat (2) @(negedge clk);
            rd_chk("status_off", 8'h60, 8'hC0);
        end
    endtask

    task t_capture;
        begin
            rsvc = 8'h5A;
            rlen = 16'hBEEF;
            rsvc_v = 1'b1;
            rlen_v = 1'b1;
            @(negedge clk);
            rsvc_v = 1'b0;
            rlen_v = 1'b0;
            rsvc = ~rsvc;
            rlen = ~rlen;
            rd_chk("rx_service", 8'h64, 8'h5A);
            rd_chk("rx_len_high", 8'h68, 8'hBE);
            rd_chk("rx_len_low", 8'h6C, 8'hEF);
        end
    endtask

    // Selector 07h must stay quiet
    task t_probe;
        begin
            for (m = 0; m < 2; m = m + 1) begin
                pa = m ? 8'h3A : 8'hC5;
                pb = ~pa;
                pc = pa ^ 8'h5F;
                pd = pa + 8'h11;
                st = m ? 5'h15 : 5'h0A;
                div = m[0];
                for (k = 0; k < 8; k = k + 1) begin
                    ep = k == 1 ? pa : k == 2 ? {pa[7], pb[6:5], 1'b0, pb[3:0]} : k == 3 ? pc : k == 4 ? pd
                       : k == 5 ? (div ? {pd[3:0], pd[7:4]} : ~pd) : k == 6 ? (pa ^ pd) : 8'h00;
                    es = (k == 0 || k == 7) ? 1'b0 : st[k > 4 ? k - 2 : k - 1];
                    i_mac_host.write_reg(8'h70, k[7:0]);
                    chk("probe", {7'h00, es, ep}, {7'h00, pstb, probe});
                    rd_chk("monitor", 8'h74, ep);
                    rd_chk("select", 8'h70, k[7:0]);
                end
            end
        end
    endtask

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            complete_run;
        end
    end

    initial begin
        rc[0] = 8'h0A;
        rc[1] = 8'h14;
        rc[2] = 8'h37;
        rc[3] = 8'h6E;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        t_reset;
        t_tx;
        t_status;
        t_capture;
        t_probe;
        complete_run;
    end
endmodule
